// ===== inc/bc4_regs.vh
// register map, field positions and reset values of the 4-bit counter
`ifndef BC4_REGS_VH
`define BC4_REGS_VH

// byte offsets of the words on the wishbone bus
`define BC4_ADR_CTRL 8'h00
`define BC4_ADR_LDATA 8'h04
`define BC4_ADR_STAT 8'h08
`define BC4_ADR_WRAPS 8'h0c

// control register fields (write-only strobes)
`define BC4_CTRL_CLEAR 0
`define BC4_CTRL_LOAD 1

// load data register field
`define BC4_LDATA_LSB 0

// status register fields
`define BC4_STAT_CNT_LSB 0
`define BC4_STAT_CARRY 4
`define BC4_STAT_WRAP 5
`define BC4_STAT_MODE_LSB 8

// one-hot codes of the last edge's operating mode
`define BC4_MODE_HOLD 4'h1
`define BC4_MODE_CLEAR 4'h2
`define BC4_MODE_LOAD 4'h4
`define BC4_MODE_COUNT 4'h8

// reset values
`define BC4_RST_COUNT 4'h0
`define BC4_RST_LDATA 4'h0
`define BC4_RST_WRAPS 16'h0000
`define BC4_RST_MODE 4'h1

`endif

// ===== hdl/bc4_bit.v
// one state bit of the counter: synchronous clear, load and toggle
`timescale 1ns/1ps

module bc4_bit (
  // clock and reset
  input wire i_mclk,
  input wire i_rst,
  // synchronous controls
  input wire i_zero,
  input wire i_load,
  input wire i_data,
  input wire i_toggle,
  // state
  output reg o_q
);

  // clear beats load beats toggle; only reset acts between edges
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_q <= 1'b0;
    end else if (i_zero) begin
      o_q <= 1'b0;
    end else if (i_load) begin
      o_q <= i_data;
    end else if (i_toggle) begin
      o_q <= ~o_q;
    end
  end

endmodule

// ===== hdl/bc4_lookahead.v
// carry look-ahead: per-bit toggle terms and the gated carry output
`timescale 1ns/1ps

module bc4_lookahead #(
  parameter WIDTH = 4
) (
  // state and enables
  input wire [WIDTH-1:0] i_q,
  input wire i_count_en,
  input wire i_trickle,
  // results
  output wire [WIDTH-1:0] o_toggle,
  output wire o_all_ones,
  output wire o_carry
);

  wire [WIDTH:0] chain;

  // running and of the lower bits, no ripple through flops
  assign chain[0] = 1'b1;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_chain
      assign chain[i+1] = chain[i] & i_q[i];
      assign o_toggle[i] = i_count_en & chain[i];
    end
  endgenerate

  // carry only sees the trickle enable, never the parallel one
  assign o_all_ones = chain[WIDTH];
  assign o_carry = i_trickle & chain[WIDTH];

endmodule

// ===== hdl/bc4_counter.v
// synchronous presettable binary counter with wishbone status port
`timescale 1ns/1ps
`include "bc4_regs.vh"

// register map: byte offsets, 32-bit words, fields in the low bits
//   0x00 control, write-only, reads zero
//     bit 0 clear strobe, zeroes the state at the following edge
//     bit 1 load strobe, copies the load data at the following edge
//   0x04 load data, read/write, bits 3:0
//   0x08 status
//     bits 3:0 current state
//     bit 4 carry output as seen now
//     bit 5 wrap flag, sticky, write one to clear
//     bits 11:8 one-hot mode of the last edge: hold, clear, load, count
//   0x0c wrap tally, read-only, counts steps from 15 to 0, rolls over
//
// bus timing
//   a request is taken at the first edge that sees cyc and stb high
//   while the slave is idle; ack and read data follow one cycle later
//   ack stays high for one cycle only, so a master that keeps stb up
//   is not answered twice for the same request
//   unmapped words answer with zero and drop writes, so a stray
//   address never stalls the bus
//   writes need byte lane 0; the other lanes hold no writable fields
//
// software strobes versus pins
//   the control strobes are registered, so they meet the counter one
//   edge after the bus write; this keeps the bus decode off the
//   count path at the price of one cycle of latency
//   a pin clear beats any load, and pin load data beats the register
//   when both ask for a load at the same edge
//
// carry output
//   the carry is the one output that is not a flop: it has to follow
//   the trickle enable within the cycle so that cascaded stages can
//   all count on the same edge
//
// reset state
//   state 0, load data 0, wrap flag and tally 0, mode hold
//   ack low until the first request, read data zero until the first read request

module bc4_counter #(
  parameter WIDTH = 4,
  parameter WRAP_W = 16
) (
  // clock and reset
  input wire i_mclk,
  input wire i_rst,

  // counter control pins
  input wire i_sync_zero_n,
  input wire i_preset_n,
  input wire i_count_enable_parallel,
  input wire i_count_enable_trickle,
  input wire [WIDTH-1:0] i_data,

  // counter outputs
  output wire [WIDTH-1:0] o_count,
  output wire o_carry_out,

  // wishbone slave
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [31:0] i_wb_dat,
  input wire [3:0] i_wb_sel,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack
);

  // bus slave states
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_ACK = 2'b10;

  // bus slave
  reg [1:0] bus_state;
  reg [1:0] next_bus_state;

  // software-side registers
  reg [WIDTH-1:0] load_data;
  reg sw_clear;
  reg sw_load;
  reg wrap_flag;
  reg [WRAP_W-1:0] wrap_count;
  reg [3:0] last_mode;

  // counter datapath
  wire [WIDTH-1:0] toggle;
  wire all_ones;
  wire carry;
  wire pin_zero;
  wire pin_load;
  wire do_zero;
  wire do_load;
  wire count_en;
  wire [WIDTH-1:0] load_value;
  wire [3:0] cur_mode;
  wire wrap_event;

  // bus decode
  wire bus_req;
  wire bus_idle;
  wire wr_ctrl;
  wire wr_ldata;
  wire wr_stat;
  wire [7:0] word_adr;
  reg [31:0] rd_word;

  // mode of the coming edge, one-hot, clear first
  function [3:0] mode_of;
    input zero;
    input load;
    input cnt;
    begin
      if (zero) begin
        mode_of = `BC4_MODE_CLEAR;
      end else if (load) begin
        mode_of = `BC4_MODE_LOAD;
      end else if (cnt) begin
        mode_of = `BC4_MODE_COUNT;
      end else begin
        mode_of = `BC4_MODE_HOLD;
      end
    end
  endfunction

  // write hit on one register word: idle slave, lane 0 only
  function wr_hit;
    input req;
    input idle;
    input we;
    input lane0;
    input [7:0] adr;
    input [7:0] target;
    begin
      wr_hit = req & idle & we & lane0 & (adr == target);
    end
  endfunction

  // pins are active low; software strobes join them
  assign pin_zero = ~i_sync_zero_n;
  assign pin_load = ~i_preset_n;
  assign do_zero = pin_zero | sw_clear;
  assign do_load = pin_load | sw_load;

  // pin data has the preset path when the pin asks for it
  assign load_value = pin_load ? i_data : load_data;

  // both enables must be high; either low holds the state
  assign count_en = i_count_enable_parallel & i_count_enable_trickle;

  // mode seen by the flops at the next edge
  assign cur_mode = mode_of(do_zero, do_load, count_en);

  // look-ahead for toggles and carry
  bc4_lookahead #(
    .WIDTH(WIDTH)
  ) u_lookahead (
    .i_q(o_count),
    .i_count_en(count_en),
    .i_trickle(i_count_enable_trickle),
    .o_toggle(toggle),
    .o_all_ones(all_ones),
    .o_carry(carry)
  );

  // carry must follow the trickle enable without a clock delay
  assign o_carry_out = carry;

  // state flops: one cell per bit, bit 0 is the lsb
  genvar b;
  generate
    for (b = 0; b < WIDTH; b = b + 1) begin : g_bit
      bc4_bit u_bit (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_zero(do_zero),
        .i_load(do_load),
        .i_data(load_value[b]),
        .i_toggle(toggle[b]),
        .o_q(o_count[b])
      );
    end
  endgenerate

  // a wrap is a counting edge leaving the top value; a clear or load
  // at the top value is not a wrap, since the count never rolled over
  assign wrap_event = (mode_of(do_zero, do_load, count_en)
                       == `BC4_MODE_COUNT) & all_ones;

  // bus request and word-aligned address
  assign bus_req = i_wb_cyc & i_wb_stb;
  assign word_adr = {i_wb_adr[7:2], 2'b00};

  // the slave takes a request only from its idle state
  assign bus_idle = (bus_state == ST_IDLE);

  // writes only land on lane 0 where all writable fields live
  assign wr_ctrl = wr_hit(bus_req, bus_idle, i_wb_we, i_wb_sel[0],
                          word_adr, `BC4_ADR_CTRL);
  assign wr_ldata = wr_hit(bus_req, bus_idle, i_wb_we, i_wb_sel[0],
                           word_adr, `BC4_ADR_LDATA);
  assign wr_stat = wr_hit(bus_req, bus_idle, i_wb_we, i_wb_sel[0],
                          word_adr, `BC4_ADR_STAT);

  // bus state machine: answer one cycle after the request
  // the ack state blocks a second take while stb is still high
  always @* begin
    next_bus_state = bus_state;
    case (bus_state)
      ST_IDLE: begin
        if (bus_req) begin
          next_bus_state = ST_ACK;
        end
      end
      ST_ACK: begin
        next_bus_state = ST_IDLE;
      end
      default: begin
        next_bus_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      bus_state <= ST_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  // ack drops the cycle after it was given
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
    end else begin
      o_wb_ack <= bus_req & (bus_state == ST_IDLE);
    end
  end

  // read mux; unmapped words read as zero but still ack
  // status shows the live state and carry, not a snapshot
  always @* begin
    rd_word = 32'h00000000;
    if (word_adr == `BC4_ADR_LDATA) begin
      rd_word[`BC4_LDATA_LSB +: WIDTH] = load_data;
    end else if (word_adr == `BC4_ADR_STAT) begin
      rd_word[`BC4_STAT_CNT_LSB +: WIDTH] = o_count;
      rd_word[`BC4_STAT_CARRY] = carry;
      rd_word[`BC4_STAT_WRAP] = wrap_flag;
      rd_word[`BC4_STAT_MODE_LSB +: 4] = last_mode;
    end else if (word_adr == `BC4_ADR_WRAPS) begin
      rd_word[WRAP_W-1:0] = wrap_count;
    end
  end

  // read data is captured with the request, stable under ack
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_wb_dat <= 32'h00000000;
    end else if (bus_req & (bus_state == ST_IDLE) & ~i_wb_we) begin
      o_wb_dat <= rd_word;
    end
  end

  // load data register, used when software presets
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      load_data <= `BC4_RST_LDATA;
    end else if (wr_ldata) begin
      load_data <= i_wb_dat[`BC4_LDATA_LSB +: WIDTH];
    end
  end

  // control strobes last one cycle, so they hit exactly one edge
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sw_clear <= 1'b0;
      sw_load <= 1'b0;
    end else begin
      sw_clear <= wr_ctrl & i_wb_dat[`BC4_CTRL_CLEAR];
      sw_load <= wr_ctrl & i_wb_dat[`BC4_CTRL_LOAD];
    end
  end

  // sticky wrap flag, write one to clear; a new wrap wins
  // so that software clearing late never loses a fresh wrap
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wrap_flag <= 1'b0;
    end else if (wrap_event) begin
      wrap_flag <= 1'b1;
    end else if (wr_stat & i_wb_dat[`BC4_STAT_WRAP]) begin
      wrap_flag <= 1'b0;
    end
  end

  // free-running wrap tally, itself wraps silently
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wrap_count <= `BC4_RST_WRAPS;
    end else if (wrap_event) begin
      wrap_count <= wrap_count + {{(WRAP_W-1){1'b0}}, 1'b1};
    end
  end

  // mode applied at the most recent edge, for software view
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      last_mode <= `BC4_RST_MODE;
    end else begin
      last_mode <= cur_mode;
    end
  end

endmodule

// ===== verif/bc4_props_properties.sv
// pin and bus checker for the 4-bit counter
`timescale 1ns/1ps
module bc4_props #(
  parameter WIDTH = 4
) (
  // clock, reset and pins
  input wire i_mclk,
  input wire i_rst,
  input wire i_sync_zero_n,
  input wire i_preset_n,
  input wire i_count_enable_parallel,
  input wire i_count_enable_trickle,
  input wire [WIDTH-1:0] i_data,
  input wire [WIDTH-1:0] o_count,
  input wire o_carry_out,
  // bus
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire o_wb_ack
);
  // a control write acts on the state at its ack edge
  wire sw = o_wb_ack & i_wb_we & i_wb_sel[0] & (i_wb_adr[7:2] == 6'h00);
  wire idle = i_sync_zero_n & i_preset_n & ~sw;
  wire both = i_count_enable_parallel & i_count_enable_trickle;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  property p_zero; !i_sync_zero_n && !sw |=> o_count == 0; endproperty
  a_zero: assert property (p_zero) else $error("no clear");
  property p_load; i_sync_zero_n && !i_preset_n && !sw |=>
    o_count == $past(i_data); endproperty
  a_load: assert property (p_load) else $error("no load");
  property p_count; idle && both |=> o_count == $past(o_count) + 1'b1;
  endproperty
  a_count: assert property (p_count) else $error("no count");
  property p_hold; idle && !both |=> $stable(o_count); endproperty
  a_hold: assert property (p_hold) else $error("no hold");
  property p_carry; o_carry_out == (i_count_enable_trickle && &o_count);
  endproperty
  a_carry: assert property (p_carry) else $error("carry");
  property p_gate; !i_count_enable_trickle |-> !o_carry_out; endproperty
  a_gate: assert property (p_gate) else $error("carry gate");
  property p_ack; $rose(i_wb_stb) |=> o_wb_ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_pulse; o_wb_ack |=> !o_wb_ack; endproperty
  a_pulse: assert property (p_pulse) else $error("long ack");
  c_wrap: cover property (idle && both && &o_count);
  c_load: cover property (!i_preset_n);
  c_bus: cover property (sw);
endmodule
bind bc4_counter bc4_props #(.WIDTH(WIDTH)) u_props (.i_mclk, .i_rst,
  .i_sync_zero_n, .i_preset_n, .i_count_enable_parallel,
  .i_count_enable_trickle, .i_data, .o_count, .o_carry_out, .i_wb_stb,
  .i_wb_we, .i_wb_adr, .i_wb_sel, .o_wb_ack);

// ===== verif/bc4_pins.sv
// far side: count-length decode on clear and a cascaded upper stage
`timescale 1ns/1ps
module bc4_pins (
  // clock, reset and requests
  input wire i_mclk,
  input wire i_rst,
  input wire i_zero_n,
  input wire i_mod_en,
  input wire [3:0] i_mod_last,
  // lower stage in, clear pin and upper stage out
  input wire [3:0] i_count,
  input wire i_carry,
  output wire o_sync_zero_n,
  output reg [3:0] o_upper
);
  // decoded last state pulls clear, so the next edge returns to zero
  assign o_sync_zero_n = i_zero_n &
    ~(i_mod_en & (i_count == i_mod_last));
  // upper nibble enabled by carry alone, same clock, no extra gating
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst)
      o_upper <= 4'h0;
    else if (!o_sync_zero_n)
      o_upper <= 4'h0;
    else if (i_carry)
      o_upper <= o_upper + 4'h1;
  end
endmodule

// ===== verif/sync_4bit_binary_counter_tb_top.sv
// random pin and bus bench for the 4-bit counter
`timescale 1ns/1ps
`include "bc4_regs.vh"
module sync_4bit_binary_counter_tb_top;
  reg clk = 0, rst = 1, zq = 1, pn = 1, ep = 0, et = 0, me = 0;
  reg cyc = 0, we = 0;
  reg [3:0] d = 4'hc, ml = 4'h0, sel = 4'hf;
  reg [7:0] a = 8'h00;
  reg [31:0] wd = 32'h0, q;
  wire [31:0] rd;
  wire [3:0] cnt, up;
  wire ack, cy, zn;
  integer mismatches = 0, compares = 0, m = 0, mu = 0, wr = 0, t = 0, i;
  initial begin
    forever #10 clk = ~clk;
  end
  bc4_pins PART (.i_mclk(clk), .i_rst(rst), .i_zero_n(zq), .i_mod_en(me),
    .i_mod_last(ml), .i_count(cnt), .i_carry(cy), .o_sync_zero_n(zn),
    .o_upper(up));
  bc4_counter DUT (.i_mclk(clk), .i_rst(rst), .i_sync_zero_n(zn),
    .i_preset_n(pn), .i_count_enable_parallel(ep),
    .i_count_enable_trickle(et), .i_data(d), .o_count(cnt),
    .o_carry_out(cy), .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we),
    .i_wb_adr(a), .i_wb_dat(wd), .i_wb_sel(sel), .o_wb_dat(rd),
    .o_wb_ack(ack));
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("wrong value %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task close_out;
    begin
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // model takes the levels seen at the edge, then pins are re-driven
  task step(input r);
    begin
      @(posedge clk);
      if (!zn) mu = 0;
      else if (et && m == 15) mu = (mu + 1) % 16;
      if (!zn) m = 0;
      else if (!pn) m = d;
      else if (ep && et) begin
        wr = wr + (m == 15);
        m = (m + 1) % 16;
      end
      zq <= !r || ($urandom % 16) != 0;
      pn <= !r || ($urandom % 8) != 0;
      ep <= r && ($urandom % 4) != 0;
      et <= r && ($urandom % 4) != 0;
      me <= r && ($urandom % 4) == 0;
      ml <= 4'($urandom);
      d <= 4'($urandom);
      #1;
      chk("count", m, cnt);
      chk("carry", et && m == 15, cy);
      chk("upper", mu, up);
    end
  endtask
  // classic single cycle, held until ack is sampled
  task wb(input w, input [7:0] ad, input [31:0] dt);
    integer n;
    begin
      @(posedge clk);
      cyc <= 1;
      we <= w;
      a <= ad;
      wd <= dt;
      n = 0;
      do begin
        @(posedge clk);
        n = n + 1;
      end while (ack !== 1'b1 && n < 20);
      chk("ack", 1, ack);
      q = rd;
      cyc <= 0;
    end
  endtask
  initial begin
    void'($urandom(32'h969e));
    repeat (20) @(posedge clk);
    rst <= 0;
    pn <= 0;
    for (i = 0; i < 400; i = i + 1)
      step(i < 399);
    wb(1, `BC4_ADR_LDATA, 32'h5);
    wb(0, `BC4_ADR_LDATA, 0);
    chk("ldata", 5, q);
    sel <= 4'he;
    wb(1, `BC4_ADR_LDATA, 32'h3);
    sel <= 4'hf;
    wb(0, `BC4_ADR_LDATA, 0);
    chk("lane", 5, q);
    wb(0, `BC4_ADR_STAT, 0);
    chk("stat", 32'h100 | (wr != 0) * 32 | m, q);
    wb(0, `BC4_ADR_WRAPS, 0);
    chk("wraps", wr % 65536, q);
    wb(1, `BC4_ADR_STAT, 32'h20);
    wb(0, `BC4_ADR_STAT, 0);
    chk("stat clr", 32'h100 | m, q);
    wb(0, 8'h10, 0);
    chk("unmapped", 0, q);
    wb(1, `BC4_ADR_CTRL, 32'h2);
    #1 chk("sw load", 5, cnt);
    wb(1, `BC4_ADR_CTRL, 32'h1);
    #1 chk("sw clear", 0, cnt);
    close_out;
  end
  // hang guard, far above the few hundred cycles of the run
  always @(posedge clk) begin
    t <= t + 1;
    if (t == 3000) begin
      mismatches = mismatches + 1;
      close_out;
    end
  end
endmodule
